// ### hdl/mte_cfg.svh
/*
  Constants of the motor target and error command block: command codes,
  error bit positions, target arithmetic and timing figures.
  Assumes inclusion by bare name from the block's package and modules.
*/
`ifndef MTE_CFG_SVH
`define MTE_CFG_SVH

// Command bytes
`define MTE_CMD_ADDR     8'hAA
`define MTE_CMD_FWD      8'hE1
`define MTE_CMD_REV      8'hE0
`define MTE_CMD_OFF      8'hFF
`define MTE_CMD_HALT     8'hB3
`define MTE_CMD_OCC      8'hB5
`define MTE_HIRES_TAG    3'h6
`define MTE_CRC_POLY     8'h91

// Target arithmetic
`define MTE_TGT_MID      12'h800
`define MTE_SPD_FULL     17'h00258
`define MTE_SPD_DIV      17'h0007F

// Error bit positions
`define MTE_EB_AWAIT     0
`define MTE_EB_NOPWR     1
`define MTE_EB_DRV       2
`define MTE_EB_INVAL     3
`define MTE_EB_INDISC    4
`define MTE_EB_FBDISC    5
`define MTE_EB_CUR       6
`define MTE_EB_FRAME     7
`define MTE_EB_OVR       8
`define MTE_EB_RXFULL    9
`define MTE_EB_CRC       10
`define MTE_EB_PROTO     11
`define MTE_EB_TMO       12
`define MTE_EB_TOP       12

// Timing
`define MTE_CLK_KHZ      200000
`define MTE_INVALID_MS   120
`define MTE_GOOD_PULSES  3'h4
`define MTE_RECOVER_CYC  1024

`endif

// ### hdl/mte_pkg.sv
/*
  Types of the motor target and error command block.
  Assumes mte_cfg.svh is on the include path.
*/
`include "mte_cfg.svh"

package mte_pkg;

  typedef enum logic [1:0] {MTE_IN_SERIAL, MTE_IN_ANALOG, MTE_IN_PULSE}
    mte_in_mode_t;

  typedef enum logic [1:0] {MTE_FB_NONE, MTE_FB_ANALOG, MTE_FB_TACHO}
    mte_fb_mode_t;

  typedef enum {MTE_IDLE, MTE_ADDR, MTE_CMD, MTE_DATA, MTE_CRCB, MTE_SKIP}
    mte_pst_t;

endpackage : mte_pkg

// ### hdl/mte_sync2.sv
/*
  Two-flop synchroniser for a group of level inputs.
  Assumes inputs asynchronous to mclk_in; the first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none

module mte_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         resetn_in,
  input  wire logic         ce_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else if (ce_in) begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule : mte_sync2

`default_nettype wire

// ### hdl/mte_crc7.sv
/*
  One-byte step of the 7-bit serial check, least significant bit first.
  Assumes the caller holds the running value between bytes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mte_cfg.svh"

module mte_crc7 (
  // Running value and new byte
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] byte_in,
  output logic      [7:0] crc_out
);

  always_comb begin
    logic [7:0] c;
    c = crc_in ^ byte_in;
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = c ^ `MTE_CRC_POLY;
      end
      c = c >> 1;
    end
    crc_out = c;
  end

endmodule : mte_crc7

`default_nettype wire

// ### hdl/mte_cmd.sv
/*
  Serial command interpreter: low and high resolution target commands,
  motor off, and the two error flag queries with two-byte replies.
  Assumes bytes from a receiver on mclk_in, a transmitter that takes a
  byte on tx_valid_out and tx_ready_in, and pin levels needing a sync.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mte_cfg.svh"

module mte_cmd
  import mte_pkg::*;
#(
  parameter int INVALID_CYC = `MTE_INVALID_MS * `MTE_CLK_KHZ,
  parameter int RECOVER_CYC = `MTE_RECOVER_CYC
) (
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  ce_in,
  // Received bytes and receiver faults
  input  wire logic [7:0]            rx_byte_in,
  input  wire logic                  rx_valid_in,
  input  wire logic                  rx_frame_err_in,
  input  wire logic                  rx_overrun_in,
  input  wire logic                  rx_drop_in,
  // Reply bytes
  output logic      [7:0]            tx_byte_out,
  output logic                       tx_valid_out,
  input  wire logic                  tx_ready_in,
  // Configuration
  input  wire mte_pkg::mte_in_mode_t in_mode_in,
  input  wire mte_pkg::mte_fb_mode_t fb_mode_in,
  input  wire logic [6:0]            dev_num_in,
  input  wire logic                  crc_en_in,
  input  wire logic                  timeout_en_in,
  input  wire logic [31:0]           timeout_cyc_in,
  input  wire logic [12:1]           halt_enable_in,
  input  wire logic [11:0]           input_min_in,
  input  wire logic [11:0]           input_max_in,
  input  wire logic [11:0]           fb_min_in,
  input  wire logic [11:0]           fb_max_in,
  input  wire logic [11:0]           current_limit_in,
  // Measurements on mclk_in
  input  wire logic                  pulse_good_in,
  input  wire logic                  pulse_bad_in,
  input  wire logic [11:0]           pulse_width_in,
  input  wire logic [11:0]           analog_input_in,
  input  wire logic [11:0]           feedback_in,
  input  wire logic [11:0]           current_in,
  // Pins
  input  wire logic                  usb_connected_in,
  input  wire logic                  motor_supply_input_in,
  input  wire logic                  driver_fault_in,
  // Motor side
  output logic      [11:0]           target_out,
  output logic      [11:0]           input_value_out,
  output logic                       motor_enable_out,
  output logic                       driver_toggle_out,
  output logic                       red_led_out,
  output logic                       err_line_out
);

  import mte_pkg::*;

  logic [2:0]  pins_s;
  logic        usb_s, sup_s, flt_s, sup_prev_q;
  mte_pst_t    st_q, st_d;
  logic [7:0]  crc_q, crc_src, crc_nx, cmd_q, cmd_d, dat_q, dat_d, cb;
  logic        go, proto_ev, crc_ev, dec, known, needs;
  logic        init_q, awaiting_q, tmo_ev;
  logic [11:0] target_q, tgt_d;
  logic [16:0] spd;
  logic [12:1] err_q;
  logic [15:0] occ_q, ev, halt_w;
  logic [15:0] tx_word_q;
  logic [1:0]  tx_cnt_q;
  logic        q_halt, q_occ, busy;
  logic [31:0] tmo_cnt_q, inv_cnt_q, rec_cnt_q;
  logic [2:0]  good_q;
  logic        invalid_q;
  logic [11:0] in_val;

  mte_sync2 #(.W(3)) u_sync (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .d_in      ({usb_connected_in, motor_supply_input_in, driver_fault_in}),
    .q_out     (pins_s)
  );
  assign {usb_s, sup_s, flt_s} = pins_s;

  mte_crc7 u_crc (
    .crc_in  (crc_src),
    .byte_in (rx_byte_in),
    .crc_out (crc_nx)
  );

  // Packet parser; a byte with its top bit set always starts a new packet
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    dat_d = dat_q;
    crc_src = crc_q;
    cb = cmd_q;
    go = 1'b0;
    proto_ev = 1'b0;
    crc_ev = 1'b0;
    dec = 1'b0;
    if (rx_valid_in && ce_in) begin
      if (rx_byte_in[7]) begin
        proto_ev = (st_q != MTE_IDLE) && (st_q != MTE_SKIP);
        crc_src = 8'h00;
        if (rx_byte_in == `MTE_CMD_ADDR) begin
          st_d = MTE_ADDR;
        end else begin
          cb = rx_byte_in;
          dec = 1'b1;
        end
      end else begin
        unique case (st_q)
          MTE_IDLE: proto_ev = 1'b1;
          MTE_SKIP: st_d = MTE_SKIP;
          MTE_ADDR: st_d = (rx_byte_in[6:0] == dev_num_in) ? MTE_CMD
                                                          : MTE_SKIP;
          MTE_CMD: begin
            cb = rx_byte_in | 8'h80;
            dec = 1'b1;
          end
          MTE_DATA: begin
            dat_d = rx_byte_in;
            st_d = crc_en_in ? MTE_CRCB : MTE_IDLE;
            go = !crc_en_in;
          end
          MTE_CRCB: begin
            st_d = MTE_IDLE;
            go = (rx_byte_in[6:0] == crc_q[6:0]);
            crc_ev = !go;
          end
        endcase
      end
      if (dec) begin
        cmd_d = cb;
        if (!known) begin
          proto_ev = 1'b1;
          st_d = MTE_IDLE;
        end else if (needs) begin
          st_d = MTE_DATA;
        end else if (crc_en_in) begin
          st_d = MTE_CRCB;
        end else begin
          go = 1'b1;
          st_d = MTE_IDLE;
        end
      end
    end
  end

  assign needs = (cb == `MTE_CMD_FWD) || (cb == `MTE_CMD_REV) ||
                 (cb[7:5] == `MTE_HIRES_TAG);
  assign known = needs || (cb == `MTE_CMD_OFF) ||
                 (cb == `MTE_CMD_HALT) || (cb == `MTE_CMD_OCC);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= MTE_IDLE;
      cmd_q <= 8'h00;
      dat_q <= 8'h00;
      crc_q <= 8'h00;
    end else if (ce_in) begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      dat_q <= dat_d;
      if (rx_valid_in) begin
        crc_q <= crc_nx;
      end
    end
  end

  // Target arithmetic; integer division truncates toward the midpoint
  assign spd = (17'(dat_d[6:0]) * `MTE_SPD_FULL) / `MTE_SPD_DIV;
  always_comb begin
    tgt_d = target_q;
    if (cmd_d[7:5] == `MTE_HIRES_TAG) begin
      tgt_d = {dat_d[6:0], cmd_d[4:0]};
    end else if (cmd_d == `MTE_CMD_FWD) begin
      tgt_d = (fb_mode_in == MTE_FB_NONE)
            ? `MTE_TGT_MID + spd[11:0]
            : `MTE_TGT_MID + {1'b0, dat_d[6:0], 4'h0};
    end else if (cmd_d == `MTE_CMD_REV) begin
      tgt_d = (fb_mode_in == MTE_FB_NONE)
            ? `MTE_TGT_MID - spd[11:0]
            : `MTE_TGT_MID - {1'b0, dat_d[6:0], 4'h0};
    end
  end

  assign busy = (tx_cnt_q != 2'h0);
  assign q_halt = go && (cmd_d == `MTE_CMD_HALT) && !busy;
  assign q_occ = go && (cmd_d == `MTE_CMD_OCC) && !busy;

  // Awaiting state is caught on the first enabled edge after reset
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      init_q <= 1'b1;
      awaiting_q <= 1'b1;
      target_q <= `MTE_TGT_MID;
    end else if (ce_in) begin
      init_q <= 1'b0;
      if (init_q) begin
        awaiting_q <= (in_mode_in == MTE_IN_SERIAL);
      end else if (go && (cmd_d == `MTE_CMD_OFF)) begin
        awaiting_q <= 1'b1;
      end else if (go && needs) begin
        awaiting_q <= (cmd_d == `MTE_CMD_REV) && (dat_d == 8'h00);
      end
      if (go && needs && in_mode_in == MTE_IN_SERIAL &&
          !((cmd_d == `MTE_CMD_REV) && (dat_d == 8'h00))) begin
        target_q <= tgt_d;
      end
    end
  end
  assign target_out = target_q;

  // Serial timeout: restarted by every valid command
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tmo_cnt_q <= 32'h0;
    end else if (ce_in) begin
      if (go || !timeout_en_in || tmo_ev) begin
        tmo_cnt_q <= 32'h0;
      end else begin
        tmo_cnt_q <= tmo_cnt_q + 32'h1;
      end
    end
  end
  assign tmo_ev = timeout_en_in && !go && (timeout_cyc_in != 32'h0) &&
                  (tmo_cnt_q >= timeout_cyc_in - 32'h1);

  // Pulse input qualification
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      good_q <= 3'h0;
      inv_cnt_q <= 32'h0;
      invalid_q <= 1'b0;
      in_val <= 12'h000;
    end else if (ce_in) begin
      if (in_mode_in != MTE_IN_PULSE) begin
        good_q <= 3'h0;
        inv_cnt_q <= 32'h0;
        invalid_q <= 1'b0;
      end else if (pulse_bad_in) begin
        good_q <= 3'h0;
        inv_cnt_q <= inv_cnt_q + 32'h1;
      end else if (pulse_good_in && good_q >= `MTE_GOOD_PULSES - 3'h1) begin
        good_q <= `MTE_GOOD_PULSES;
        in_val <= pulse_width_in;
        inv_cnt_q <= 32'h0;
        invalid_q <= 1'b0;
      end else begin
        if (pulse_good_in) begin
          good_q <= good_q + 3'h1;
        end
        if (inv_cnt_q > 32'(INVALID_CYC)) begin
          invalid_q <= 1'b1;
        end else begin
          inv_cnt_q <= inv_cnt_q + 32'h1;
        end
      end
    end
  end
  assign input_value_out = (in_mode_in == MTE_IN_PULSE) ? in_val
                                                        : analog_input_in;

  // Driver recovery: pulse the toggle line periodically while faulted
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rec_cnt_q <= 32'h0;
      driver_toggle_out <= 1'b0;
      sup_prev_q <= 1'b0;
    end else if (ce_in) begin
      sup_prev_q <= sup_s;
      driver_toggle_out <= flt_s && (rec_cnt_q == 32'(RECOVER_CYC - 1));
      if (!flt_s || rec_cnt_q == 32'(RECOVER_CYC - 1)) begin
        rec_cnt_q <= 32'h0;
      end else begin
        rec_cnt_q <= rec_cnt_q + 32'h1;
      end
    end
  end

  // Error events of this cycle
  always_comb begin
    ev = 16'h0000;
    ev[`MTE_EB_AWAIT] = awaiting_q;
    ev[`MTE_EB_NOPWR] = usb_s && !sup_s;
    ev[`MTE_EB_DRV] = flt_s || (usb_s && sup_prev_q && !sup_s);
    ev[`MTE_EB_INVAL] = invalid_q;
    ev[`MTE_EB_INDISC] = (input_value_out > input_max_in) ||
                         (input_value_out < input_min_in);
    ev[`MTE_EB_FBDISC] = (feedback_in > fb_max_in) ||
                         (feedback_in < fb_min_in);
    ev[`MTE_EB_CUR] = current_in > current_limit_in;
    ev[`MTE_EB_FRAME] = rx_frame_err_in;
    ev[`MTE_EB_OVR] = rx_overrun_in;
    ev[`MTE_EB_RXFULL] = rx_drop_in;
    ev[`MTE_EB_CRC] = crc_ev;
    ev[`MTE_EB_PROTO] = proto_ev;
    ev[`MTE_EB_TMO] = tmo_ev;
  end

  // Latched errors: a new event wins over the clear in the same cycle
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_q <= 12'h000;
      occ_q <= 16'h0000;
    end else if (ce_in) begin
      err_q <= (q_halt ? 12'h000 : err_q) |
               (ev[`MTE_EB_TOP:1] & halt_enable_in);
      occ_q <= (q_occ ? 16'h0000 : occ_q) | ev;
    end
  end
  assign halt_w = {3'h0, err_q, awaiting_q};

  // Two-byte reply, low byte first
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_word_q <= 16'h0000;
      tx_byte_out <= 8'h00;
      tx_cnt_q <= 2'h0;
    end else if (ce_in) begin
      if (q_halt || q_occ) begin
        tx_word_q <= q_halt ? halt_w : occ_q;
        tx_byte_out <= q_halt ? halt_w[7:0] : occ_q[7:0];
        tx_cnt_q <= 2'h2;
      end else if (busy && tx_ready_in) begin
        tx_byte_out <= tx_word_q[15:8];
        tx_cnt_q <= tx_cnt_q - 2'h1;
      end
    end
  end
  assign tx_valid_out = busy;

  assign motor_enable_out = !awaiting_q && (err_q == 12'h000);
  assign red_led_out = |err_q;
  assign err_line_out = |err_q;

  fwd_target_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    go && cmd_d == `MTE_CMD_FWD && in_mode_in == MTE_IN_SERIAL &&
    fb_mode_in != MTE_FB_NONE && !init_q
    |=> target_out == 12'h800 + {1'b0, $past(dat_d[6:0]), 4'h0})
    else $error("forward target wrong");

  speed_fwd_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    go && cmd_d == `MTE_CMD_FWD && dat_d == 8'h7F &&
    in_mode_in == MTE_IN_SERIAL && fb_mode_in == MTE_FB_NONE
    |=> target_out == 12'hA58)
    else $error("full forward speed target wrong");

  speed_rev_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    go && cmd_d == `MTE_CMD_REV && dat_d == 8'h7F &&
    in_mode_in == MTE_IN_SERIAL && fb_mode_in == MTE_FB_NONE
    |=> target_out == 12'h5A8)
    else $error("full reverse speed target wrong");

  rev_off_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    go && cmd_d == `MTE_CMD_REV && dat_d == 8'h00 && !init_q
    |=> awaiting_q && !motor_enable_out && $stable(target_out))
    else $error("reverse zero did not stop motor");

  rev_clear_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    go && cmd_d == `MTE_CMD_REV && dat_d != 8'h00 && !init_q
    |=> !awaiting_q)
    else $error("reverse did not clear awaiting");

  reply_order_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    ce_in && tx_cnt_q == 2'h2 && tx_ready_in && !q_halt && !q_occ
    |=> tx_byte_out == $past(tx_word_q[15:8]) && tx_cnt_q == 2'h1)
    else $error("reply byte order wrong");

  crc_drop_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    ce_in && crc_ev |=> $stable(target_out) && err_q[`MTE_EB_CRC] ==
    halt_enable_in[`MTE_EB_CRC])
    else $error("bad check byte not discarded");

  halt_clear_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    q_halt && (ev[12:1] & halt_enable_in) == 12'h000
    |=> err_q == 12'h000 ##0 tx_word_q[15:13] == 3'h0)
    else $error("halting query did not clear");

  occ_keep_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    q_occ && ev[`MTE_EB_PROTO]
    |=> occ_q[`MTE_EB_PROTO] && tx_word_q == $past(occ_q))
    else $error("occurred report lost event");

  err_line_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    err_q != 12'h000 |-> err_line_out && red_led_out && !motor_enable_out)
    else $error("error line not driven");

endmodule : mte_cmd

`default_nettype wire

// ### dv/mte_host.sv
/*
  Host model: sends command bytes to the block and takes its
  two-byte replies, promptly or after a stall.
  Assumes the byte input and reply handshake run on mclk_in.
*/
`timescale 1ns/1ps
`default_nettype none

module mte_host (
  // Clock
  input  wire logic       mclk_in,
  // Bytes to the block
  output var logic [7:0]  rx_byte_out,
  output var logic        rx_valid_out,
  // Replies from the block
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_valid_in,
  output var logic        tx_ready_out
);
  initial begin
    rx_byte_out  = 8'hA5;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end

  // One byte per call, then a gap cycle
  task automatic send(input logic [7:0] b);
    @(posedge mclk_in);
    #1;
    rx_byte_out  = b;
    rx_valid_out = 1'b1;
    @(posedge mclk_in);
    #1;
    rx_valid_out = 1'b0;
    // Idle bus shows garbage so a stale byte never passes for data
    rx_byte_out  = ~b;
  endtask : send

  // Low byte arrives first; after 20 cycles without a reply, whatever byte is on tx_byte_in is read
  task automatic take(input int stall, output logic [15:0] w);
    int n;
    n = 0;
    w = 16'hXXXX;
    while (tx_valid_in !== 1'b1 && n < 20) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    // Bytes are read off the edge, where they have settled
    w[7:0] = tx_byte_in;
    repeat (stall) @(posedge mclk_in);
    #1;
    tx_ready_out = 1'b1;
    @(posedge mclk_in);
    #1;
    w[15:8] = tx_byte_in;
    @(posedge mclk_in);
    #1;
    tx_ready_out = 1'b0;
  endtask : take
endmodule : mte_host

`default_nettype wire

// ### dv/tb_top.sv
/*
  Bench for the command interpreter: packets go through the host model,
  targets, flags and replies are compared with worked-out values.
  Assumes short invalid and recovery counts given at the instance.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import mte_pkg::*;
  logic         mclk_in, resetn_in, ce_in, crc_en, tmo_en, crc_flip;
  logic [7:0]   rx_byte, tx_byte;
  logic         rx_valid, tx_valid, tx_ready, frame_err, overrun, drop;
  logic         pgood, pbad, usb, supply, fault, m_en, toggle, led, err_ln;
  mte_in_mode_t in_mode;
  mte_fb_mode_t fb_mode;
  logic [31:0]  tmo_cyc;
  logic [11:0]  halt_en, lim_lo, lim_hi, pwidth, ain, fb, cur, target, in_val;
  int           bad_count, compares;
  // {feedback mode, command, magnitude, expected target}
  logic [31:0]  tv [8] = '{32'h0E17FA58, 32'h0E101804, 32'h0E07F5A8,
    32'h0E0017FC, 32'h1E17FFF0, 32'h1E07F010, 32'h2E101810, 32'h2E0027E0};

  mte_host u_mte_host (.mclk_in(mclk_in), .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid), .tx_byte_in(tx_byte), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready));

  mte_cmd #(.INVALID_CYC(200), .RECOVER_CYC(8)) u_mte_cmd (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_frame_err_in(frame_err),
    .rx_overrun_in(overrun), .rx_drop_in(drop), .tx_byte_out(tx_byte),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .in_mode_in(in_mode),
    .fb_mode_in(fb_mode), .dev_num_in(7'h0B), .crc_en_in(crc_en),
    .timeout_en_in(tmo_en), .timeout_cyc_in(tmo_cyc),
    .halt_enable_in(halt_en), .input_min_in(lim_lo), .input_max_in(lim_hi),
    .fb_min_in(lim_lo), .fb_max_in(lim_hi), .current_limit_in(12'h400),
    .pulse_good_in(pgood), .pulse_bad_in(pbad), .pulse_width_in(pwidth),
    .analog_input_in(ain), .feedback_in(fb), .current_in(cur),
    .usb_connected_in(usb), .motor_supply_input_in(supply),
    .driver_fault_in(fault), .target_out(target), .input_value_out(in_val),
    .motor_enable_out(m_en), .driver_toggle_out(toggle), .red_led_out(led),
    .err_line_out(err_ln));

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic summarize();
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask : wait_cyc

  function automatic logic [7:0] crc_step(input logic [7:0] c, b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      if (r[0]) r = r ^ 8'h91;
      r = r >> 1;
    end
    return r;
  endfunction : crc_step

  // Check byte is appended whenever checking is on; crc_flip spoils it
  task automatic pkt(input int n, input logic [7:0] a, b, c, d);
    logic [7:0] s [4];
    logic [7:0] cr;
    s = '{a, b, c, d};
    cr = 8'h00;
    for (int i = 0; i < n; i++) begin
      u_mte_host.send(s[i]);
      cr = crc_step(cr, s[i]);
    end
    if (crc_en) u_mte_host.send(cr ^ {7'h00, crc_flip});
  endtask : pkt

  task automatic query(input logic [7:0] c, input int st, input logic [15:0] e);
    logic [15:0] w;
    pkt(1, c, 8'h00, 8'h00, 8'h00);
    u_mte_host.take(st, w);
    chk(w, e);
  endtask : query

  task automatic ev(input logic [2:0] e);
    {frame_err, overrun, drop} = e;
    wait_cyc(1);
    {frame_err, overrun, drop} = 3'h0;
  endtask : ev

  task automatic pulses(input int n, input logic [11:0] w, input logic g);
    repeat (n) begin
      wait_cyc(1);
      {pgood, pbad, pwidth} = {g, !g, w};
      wait_cyc(1);
      {pgood, pbad} = 2'h0;
    end
  endtask : pulses

  initial begin
    #100us;
    bad_count++;
    summarize();
  end

  initial begin
    logic [15:0] w;
    int n;
    {resetn_in, ce_in, crc_en, tmo_en, crc_flip, usb, fault} = 7'h22;
    {frame_err, overrun, drop, pgood, pbad, supply} = 6'h01;
    in_mode = MTE_IN_SERIAL;
    fb_mode = MTE_FB_NONE;
    tmo_cyc = 32'h0;
    {halt_en, lim_lo, lim_hi, pwidth} = {12'hEFF, 12'h000, 12'hFF0, 12'h0};
    {ain, fb, cur} = {12'h800, 12'h800, 12'h100};
    repeat (3) @(posedge mclk_in);
    #1;
    resetn_in = 1'b1;
    wait_cyc(4);
    chk({4'h0, target}, 16'h0800);
    chk({15'h0, m_en}, 16'h0000);
    query(8'hB3, 0, 16'h0001);
    pkt(1, 8'hB5, 8'h00, 8'h00, 8'h00);
    u_mte_host.take(0, w);
    foreach (tv[i]) begin
      fb_mode = mte_fb_mode_t'(tv[i][29:28]);
      pkt(2, tv[i][27:20], tv[i][19:12], 8'h00, 8'h00);
      wait_cyc(2);
      chk({4'h0, target}, {4'h0, tv[i][11:0]});
      chk({15'h0, m_en}, 16'h0001);
    end
    pkt(2, 8'hE0, 8'h00, 8'h00, 8'h00);
    wait_cyc(2);
    chk({3'h0, m_en, target}, 16'h07E0);
    query(8'hB3, 2, 16'h0001);
    query(8'hB3, 0, 16'h0001);
    fb_mode = MTE_FB_ANALOG;
    pkt(4, 8'hAA, 8'h0B, 8'h61, 8'h10);
    pkt(4, 8'hAA, 8'h05, 8'h61, 8'h20);
    wait_cyc(2);
    chk({3'h0, m_en, target}, 16'h1900);
    pkt(3, 8'hAA, 8'h0B, 8'h35, 8'h00);
    u_mte_host.take(1, w);
    chk(w, 16'h0001);
    query(8'hB5, 0, 16'h0000);
    ev(3'b100);
    wait_cyc(2);
    chk({13'h0, m_en, led, err_ln}, 16'h0003);
    query(8'hB5, 0, 16'h0080);
    query(8'hB3, 3, 16'h0080);
    chk({13'h0, m_en, led, err_ln}, 16'h0004);
    ev(3'b011);
    query(8'hB3, 0, 16'h0100);
    query(8'hB5, 1, 16'h0300);
    cur = 12'h401;
    wait_cyc(3);
    cur = 12'h100;
    query(8'hB3, 0, 16'h0040);
    query(8'hB5, 0, 16'h0040);
    pkt(1, 8'hA1, 8'h00, 8'h00, 8'h00);
    pkt(1, 8'hE1, 8'h00, 8'h00, 8'h00);
    pkt(2, 8'hE1, 8'h40, 8'h00, 8'h00);
    wait_cyc(2);
    chk({4'h0, target}, 16'h0C00);
    query(8'hB5, 0, 16'h0800);
    query(8'hB3, 0, 16'h0800);
    crc_en = 1'b1;
    pkt(2, 8'hE1, 8'h10, 8'h00, 8'h00);
    crc_flip = 1'b1;
    pkt(2, 8'hE1, 8'h20, 8'h00, 8'h00);
    crc_flip = 1'b0;
    wait_cyc(2);
    chk({4'h0, target}, 16'h0900);
    query(8'hB5, 0, 16'h0400);
    query(8'hB3, 0, 16'h0400);
    {crc_en, tmo_en, tmo_cyc} = {2'b01, 32'd40};
    wait_cyc(50);
    tmo_en = 1'b0;
    query(8'hB5, 0, 16'h1000);
    query(8'hB3, 0, 16'h1000);
    {usb, supply} = 2'b10;
    wait_cyc(6);
    query(8'hB5, 0, 16'h0006);
    {usb, supply} = 2'b01;
    wait_cyc(4);
    query(8'hB3, 0, 16'h0006);
    pkt(1, 8'hB5, 8'h00, 8'h00, 8'h00);
    u_mte_host.take(0, w);
    fault = 1'b1;
    n = 0;
    while (toggle !== 1'b1 && n < 20) begin
      wait_cyc(1);
      n++;
    end
    chk({15'h0, toggle}, 16'h0001);
    fault = 1'b0;
    wait_cyc(4);
    query(8'hB5, 0, 16'h0004);
    query(8'hB3, 0, 16'h0004);
    fb = 12'hFFF;
    wait_cyc(3);
    {fb, ain} = {12'h800, 12'hFFF};
    in_mode = MTE_IN_ANALOG;
    wait_cyc(3);
    ain = 12'h800;
    in_mode = MTE_IN_SERIAL;
    wait_cyc(2);
    query(8'hB5, 0, 16'h0030);
    query(8'hB3, 0, 16'h0030);
    in_mode = MTE_IN_PULSE;
    pulses(4, 12'h123, 1'b1);
    wait_cyc(2);
    chk({4'h0, in_val}, 16'h0123);
    pulses(3, 12'h123, 1'b1);
    pulses(1, 12'h456, 1'b0);
    pulses(3, 12'h456, 1'b1);
    wait_cyc(2);
    chk({4'h0, in_val}, 16'h0123);
    wait_cyc(210);
    query(8'hB5, 0, 16'h0008);
    pulses(4, 12'h789, 1'b1);
    wait_cyc(2);
    chk({4'h0, in_val}, 16'h0789);
    query(8'hB3, 0, 16'h0008);
    query(8'hB3, 0, 16'h0000);
    summarize();
  end
endmodule : tb_top

`default_nettype wire
